// ==== verilog/slbet_top.sv ====
`timescale 1ns/1ns
module slbet_top
  import slbet_pkg::*;
#(
  parameter int FREQ_GATE_CYC = FREQ_GATE_US * MCLK_MHZ
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        link_clk_i,
  input  wire logic        rx_serial_i,
  output logic             tx_serial_o,
  input  wire logic        tx_user_clock_i,
  input  wire logic        tx_user_clock_half_i,
  input  wire logic        rx_user_clock_i,
  input  wire logic        rx_user_clock_half_i,
  output logic             tx_cm_reset_o,
  output logic             rx_cm_reset_o,
  output logic [7:0]       dcfg_addr_o,
  output logic [15:0]      dcfg_di_o,
  output logic             dcfg_en_o,
  output logic             dcfg_we_o,
  input  wire logic [15:0] dcfg_do_i,
  input  wire logic        dcfg_rdy_i,
  output logic [15:0]      port_ctrl_o,
  input  wire logic [15:0] port_stat_i,
  output logic             rx_ac_couple_o,
  output logic [1:0]       rx_term_sel_o,
  output logic [7:0]       tx_swing_o,
  output logic [7:0]       tx_preemph_o,
  output logic [7:0]       receive_equalization_o,
  output logic [7:0]       feedback_eq_tap_one_o,
  output logic [7:0]       feedback_eq_tap_two_o,
  output logic [6:0]       rx_sample_o
);

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // effective end: never below start, sampling point clamped
  function automatic logic [7:0] sw_end(input logic [15:0] rng, input int idx);
    logic [7:0] e;
    e = rng[15:8];
    if (idx == SW_SAMPLE && e > SAMPLE_MAX) begin
      e = SAMPLE_MAX;
    end
    if (e < rng[7:0]) begin
      e = rng[7:0];
    end
    return e;
  endfunction

  // ***************************************
  // declarations
  // ***************************************
  logic [21:0] meta_reg;
  logic [21:0] sync_reg;
  logic [4:0]  prev_reg;
  logic        link_rise;
  logic        rx_bit;
  logic [31:0] ctrl_reg;
  logic        ack_reg;
  logic        ack_set;
  logic        req;
  logic        dcfg_sel;
  logic        dcfg_busy_reg;
  logic        wr_fire;
  logic [7:0]  cmd;
  logic [31:0] rdata_next;
  logic        gen_bit;
  logic        chk_bit;
  logic        inject_reg;
  logic        tx_bit_reg;
  logic [5:0]  good_cnt_reg;
  logic        locked_reg;
  logic [31:0] bit_cnt_reg;
  logic [31:0] err_cnt_reg;
  logic [3:0]  cm_cnt_reg [2];
  logic [1:0]  cm_rst_reg;
  logic [31:0] gate_cnt_reg;
  logic [15:0] edge_cnt_reg [4];
  logic [15:0] freq_reg [4];
  logic [15:0] port_ctrl_reg;
  logic [15:0] range_reg [SW_NUM];
  logic [7:0]  cur_reg [SW_NUM];
  logic [7:0]  cur_next [SW_NUM];
  logic        sw_last;
  logic [31:0] sw_total;
  logic [31:0] dwell_reg;
  logic [31:0] dwell_cnt_reg;
  logic [31:0] iter_reg;
  slbet_sw_e   sw_state_reg;

  // ***************************************
  // input synchronisers
  // ***************************************
  // two stages for every asynchronous input
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      meta_reg <= 22'h00_0000;
      sync_reg <= 22'h00_0000;
    end else begin
      meta_reg <= {port_stat_i, rx_user_clock_half_i, rx_user_clock_i, tx_user_clock_half_i,
                   tx_user_clock_i, rx_serial_i, link_clk_i};
      sync_reg <= meta_reg;
    end
  end

  // previous levels for edge detection
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prev_reg <= 5'h00;
    end else begin
      prev_reg <= {sync_reg[5:2], sync_reg[0]};
    end
  end

  assign link_rise = sync_reg[0] & ~prev_reg[0];
  assign rx_bit    = sync_reg[1] ^ ctrl_reg[CTRL_RX_POL];

  // ***************************************
  // avalon slave
  // ***************************************
  assign req      = avs_read_i | avs_write_i;
  assign dcfg_sel = (avs_address_i == OFS_DCFG_DATA);
  assign ack_set  = req & ~ack_reg & (~dcfg_sel | (dcfg_busy_reg & dcfg_rdy_i));
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_fire  = avs_write_i & ack_reg;
  assign cmd      = (wr_fire && avs_address_i == OFS_CMD) ? avs_writedata_i[7:0] : 8'h00;

  // one-cycle answer window
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_set;
    end
  end

  // read data selection
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (avs_address_i == OFS_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (avs_address_i == OFS_STATUS) begin
      rdata_next = {24'h00_0000, sw_state_reg, cm_rst_reg, inject_reg, locked_reg};
    end else if (avs_address_i == OFS_BIT_CNT) begin
      rdata_next = bit_cnt_reg;
    end else if (avs_address_i == OFS_ERR_CNT) begin
      rdata_next = err_cnt_reg;
    end else if (avs_address_i >= OFS_FREQ && avs_address_i < OFS_DCFG_ADDR) begin
      rdata_next = {16'h0000, freq_reg[avs_address_i[3:2] - 2'h1]};
    end else if (avs_address_i == OFS_DCFG_ADDR) begin
      rdata_next = {24'h00_0000, dcfg_addr_o};
    end else if (dcfg_sel) begin
      rdata_next = {16'h0000, dcfg_do_i};
    end else if (avs_address_i == OFS_PORT_CTRL) begin
      rdata_next = {16'h0000, port_ctrl_reg};
    end else if (avs_address_i == OFS_PORT_STAT) begin
      rdata_next = {16'h0000, sync_reg[21:6]};
    end else if (avs_address_i == OFS_SW_DWELL) begin
      rdata_next = dwell_reg;
    end else if (avs_address_i == OFS_SW_ITER) begin
      rdata_next = iter_reg;
    end else if (avs_address_i == OFS_SW_TOTAL) begin
      rdata_next = sw_total;
    end else if (avs_address_i >= OFS_SW_RANGE && avs_address_i < OFS_SW_RANGE + 8'h18) begin
      rdata_next = {16'h0000, range_reg[3'((avs_address_i - OFS_SW_RANGE) >> 2)]};
    end
  end

  // read data captured as the answer opens
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ack_set && avs_read_i) begin
      avs_readdata_o <= rdata_next;
    end
  end

  // ***************************************
  // control registers
  // ***************************************
  // control word, patterns, coupling and termination
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && avs_address_i == OFS_CTRL) begin
      ctrl_reg <= be_merge(ctrl_reg, avs_writedata_i, avs_byteenable_i);
    end
  end

  assign rx_ac_couple_o = ctrl_reg[CTRL_AC_CPL];
  assign rx_term_sel_o  = ctrl_reg[CTRL_TERM_LO +: 2];

  // writable transceiver control ports
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      port_ctrl_reg <= 16'h0000;
    end else if (wr_fire && avs_address_i == OFS_PORT_CTRL) begin
      port_ctrl_reg <= 16'(be_merge({16'h0000, port_ctrl_reg}, avs_writedata_i, avs_byteenable_i));
    end
  end

  assign port_ctrl_o = port_ctrl_reg;

  // ***************************************
  // dynamic config port
  // ***************************************
  // address latch
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dcfg_addr_o <= 8'h00;
    end else if (wr_fire && avs_address_i == OFS_DCFG_ADDR) begin
      dcfg_addr_o <= avs_writedata_i[7:0];
    end
  end

  // one port cycle per bus access, bus held until ready
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dcfg_busy_reg <= 1'b0;
      dcfg_en_o     <= 1'b0;
      dcfg_we_o     <= 1'b0;
      dcfg_di_o     <= 16'h0000;
    end else begin
      dcfg_en_o <= 1'b0;
      dcfg_we_o <= 1'b0;
      if (req && dcfg_sel && !ack_reg && !dcfg_busy_reg) begin
        dcfg_busy_reg <= 1'b1;
        dcfg_en_o     <= 1'b1;
        dcfg_we_o     <= avs_write_i;
        dcfg_di_o     <= avs_writedata_i[15:0];
      end else if (dcfg_busy_reg && dcfg_rdy_i) begin
        dcfg_busy_reg <= 1'b0;
      end
    end
  end

  // ***************************************
  // pattern generator and checker
  // ***************************************
  slbet_pattern u_gen (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .step_i    (link_rise),
    .sel_i     (ctrl_reg[CTRL_TXPAT_LO +: 3]),
    .bit_i     (gen_bit),
    .predict_o (gen_bit)
  );

  // checker follows the line until locked, then runs free
  slbet_pattern u_chk (
    .mclk_i    (mclk_i),
    .resetn_i  (resetn_i),
    .step_i    (link_rise),
    .sel_i     (ctrl_reg[CTRL_RXPAT_LO +: 3]),
    .bit_i     (locked_reg ? chk_bit : rx_bit),
    .predict_o (chk_bit)
  );

  // transmit bit, one inverted bit per inject
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      tx_bit_reg <= 1'b0;
      inject_reg <= 1'b0;
    end else begin
      if (link_rise) begin
        tx_bit_reg <= gen_bit ^ inject_reg ^ ctrl_reg[CTRL_TX_POL];
      end
      if (cmd[CMD_INJECT]) begin
        inject_reg <= 1'b1;
      end else if (link_rise) begin
        inject_reg <= 1'b0;
      end
    end
  end

  assign tx_serial_o = tx_bit_reg;

  // lock after a run of matching bits
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      good_cnt_reg <= 6'h00;
      locked_reg   <= 1'b0;
    end else if (cmd[CMD_CNT_RST] || (wr_fire && avs_address_i == OFS_CTRL)) begin
      good_cnt_reg <= 6'h00;
      locked_reg   <= 1'b0;
    end else if (link_rise && !locked_reg) begin
      if (rx_bit != chk_bit) begin
        good_cnt_reg <= 6'h00;
      end else if (good_cnt_reg == LOCK_BITS - 6'h01) begin
        locked_reg <= 1'b1;
      end else begin
        good_cnt_reg <= good_cnt_reg + 6'h01;
      end
    end
  end

  // ***************************************
  // bit and error counters
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      bit_cnt_reg <= 32'h0000_0000;
      err_cnt_reg <= 32'h0000_0000;
    end else if (cmd[CMD_CNT_RST]) begin
      bit_cnt_reg <= 32'h0000_0000;
      err_cnt_reg <= 32'h0000_0000;
    end else if (link_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 32'h0000_0001;
      if (locked_reg && rx_bit != chk_bit) begin
        err_cnt_reg <= err_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ***************************************
  // clock manager resets
  // ***************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cm_cnt_reg[0] <= 4'h0;
      cm_cnt_reg[1] <= 4'h0;
      cm_rst_reg    <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cmd[CMD_TXCM_RST + i]) begin
          cm_cnt_reg[i] <= 4'(CM_RST_CYC - 1);
          cm_rst_reg[i] <= 1'b1;
        end else if (cm_cnt_reg[i] != 4'h0) begin
          cm_cnt_reg[i] <= cm_cnt_reg[i] - 4'h1;
        end else begin
          cm_rst_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign tx_cm_reset_o = cm_rst_reg[0];
  assign rx_cm_reset_o = cm_rst_reg[1];

  // ***************************************
  // user clock frequency meter
  // ***************************************
  // edges counted over a fixed gate of system clock
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      gate_cnt_reg <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        edge_cnt_reg[i] <= 16'h0000;
        freq_reg[i]     <= 16'h0000;
      end
    end else begin
      if (gate_cnt_reg == 32'(FREQ_GATE_CYC - 1)) begin
        gate_cnt_reg <= 32'h0000_0000;
      end else begin
        gate_cnt_reg <= gate_cnt_reg + 32'h0000_0001;
      end
      for (int i = 0; i < 4; i++) begin
        if (gate_cnt_reg == 32'(FREQ_GATE_CYC - 1)) begin
          freq_reg[i]     <= edge_cnt_reg[i];
          edge_cnt_reg[i] <= 16'h0000;
        end else if (sync_reg[i + 2] && !prev_reg[i + 1]) begin
          edge_cnt_reg[i] <= edge_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // ***************************************
  // sweep controller
  // ***************************************
  // range registers, start low byte, end next byte
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dwell_reg <= 32'h0000_0001;
      for (int i = 0; i < SW_NUM; i++) begin
        range_reg[i] <= 16'h0000;
      end
    end else if (wr_fire && sw_state_reg != SLBET_SW_RUN && sw_state_reg != SLBET_SW_PAUSE) begin
      if (avs_address_i == OFS_SW_DWELL) begin
        dwell_reg <= be_merge(dwell_reg, avs_writedata_i, avs_byteenable_i);
      end
      for (int i = 0; i < SW_NUM; i++) begin
        if (avs_address_i == OFS_SW_RANGE + 8'(4 * i)) begin
          range_reg[i] <= avs_writedata_i[15:0];
        end
      end
    end
  end

  // total iterations and next nested step
  always_comb begin
    logic carry;
    carry    = 1'b1;
    sw_last  = 1'b1;
    sw_total = 32'h0000_0001;
    for (int i = SW_NUM - 1; i >= 0; i--) begin
      sw_total = 32'(sw_total * 32'(sw_end(range_reg[i], i) - range_reg[i][7:0] + 9'h001));
      cur_next[i] = cur_reg[i];
      if (cur_reg[i] < sw_end(range_reg[i], i)) begin
        sw_last = 1'b0;
      end
      if (carry) begin
        if (cur_reg[i] >= sw_end(range_reg[i], i)) begin
          cur_next[i] = range_reg[i][7:0];
        end else begin
          cur_next[i] = cur_reg[i] + 8'h01;
          carry = 1'b0;
        end
      end
    end
  end

  // sweep state, dwell timer and iteration number
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sw_state_reg  <= SLBET_SW_IDLE;
      dwell_cnt_reg <= 32'h0000_0000;
      iter_reg      <= 32'h0000_0000;
      for (int i = 0; i < SW_NUM; i++) begin
        cur_reg[i] <= 8'h00;
      end
    end else if (cmd[CMD_SW_RESET]) begin
      sw_state_reg <= SLBET_SW_IDLE;
    end else begin
      case (sw_state_reg)
        SLBET_SW_IDLE, SLBET_SW_DONE: begin
          if (cmd[CMD_SW_START]) begin
            sw_state_reg  <= SLBET_SW_RUN;
            dwell_cnt_reg <= 32'h0000_0000;
            iter_reg      <= 32'h0000_0000;
            for (int i = 0; i < SW_NUM; i++) begin
              cur_reg[i] <= range_reg[i][7:0];
            end
          end
        end
        SLBET_SW_RUN: begin
          if (cmd[CMD_SW_PAUSE]) begin
            sw_state_reg <= SLBET_SW_PAUSE;
          end else if (dwell_cnt_reg + 32'h0000_0001 >= dwell_reg) begin
            dwell_cnt_reg <= 32'h0000_0000;
            if (sw_last) begin
              sw_state_reg <= SLBET_SW_DONE;
            end else begin
              iter_reg <= iter_reg + 32'h0000_0001;
              for (int i = 0; i < SW_NUM; i++) begin
                cur_reg[i] <= cur_next[i];
              end
            end
          end else begin
            dwell_cnt_reg <= dwell_cnt_reg + 32'h0000_0001;
          end
        end
        SLBET_SW_PAUSE: begin
          if (cmd[CMD_SW_RESUME]) begin
            sw_state_reg <= SLBET_SW_RUN;
          end
        end
        default: begin
          sw_state_reg <= SLBET_SW_IDLE;
        end
      endcase
    end
  end

  // swept settings to the transceiver
  assign tx_swing_o             = cur_reg[0];
  assign tx_preemph_o           = cur_reg[1];
  assign receive_equalization_o = cur_reg[2];
  assign feedback_eq_tap_one_o  = cur_reg[3];
  assign feedback_eq_tap_two_o  = cur_reg[4];
  assign rx_sample_o            = cur_reg[SW_SAMPLE][6:0];

endmodule

// ==== shared/slbet_pkg.sv ====
// Notes on behaviour
// - rx polarity invert flips incoming bits first
// - prbs 7/15/23/31 and 2x/10x clock patterns
// - tx and rx pattern selects are independent
// - received bit counter accumulates every bit
// - error counter accumulates checker mismatches
// - both counters readable for ratio calculation
// - tester reset clears both counters
// - tx clock manager reset command
// - rx clock manager reset command
// - four user clock frequencies measured
// - config port writes immediate, all readable
// - control ports writable, status read-only
// - sweep nests, first parameter outermost
// - equal start and end holds parameter
// - default sweep set swing to taps
// - sampling point 128 positions, region swept
// - sweep pause, resume, reset, iteration shown
// - ac coupling bit and termination select
// - error inject flips exactly one bit
package slbet_pkg;

  // ***************************************
  // register byte offsets
  // ***************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_BIT_CNT   = 8'h0c;
  localparam logic [7:0] OFS_ERR_CNT   = 8'h10;
  localparam logic [7:0] OFS_FREQ      = 8'h14;
  localparam logic [7:0] OFS_DCFG_ADDR = 8'h24;
  localparam logic [7:0] OFS_DCFG_DATA = 8'h28;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h2c;
  localparam logic [7:0] OFS_PORT_STAT = 8'h30;
  localparam logic [7:0] OFS_SW_DWELL  = 8'h34;
  localparam logic [7:0] OFS_SW_ITER   = 8'h38;
  localparam logic [7:0] OFS_SW_TOTAL  = 8'h3c;
  localparam logic [7:0] OFS_SW_RANGE  = 8'h40;

  // ***************************************
  // control and command fields
  // ***************************************
  localparam int CTRL_RX_POL  = 0;
  localparam int CTRL_TX_POL  = 1;
  localparam int CTRL_AC_CPL  = 2;
  localparam int CTRL_TERM_LO = 3;
  localparam int CTRL_TXPAT_LO = 8;
  localparam int CTRL_RXPAT_LO = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam int CMD_CNT_RST  = 0;
  localparam int CMD_INJECT   = 1;
  localparam int CMD_TXCM_RST = 2;
  localparam int CMD_RXCM_RST = 3;
  localparam int CMD_SW_START = 4;
  localparam int CMD_SW_PAUSE = 5;
  localparam int CMD_SW_RESUME = 6;
  localparam int CMD_SW_RESET = 7;

  // ***************************************
  // patterns
  // ***************************************
  localparam logic [2:0] PAT_PRBS7  = 3'h0;
  localparam logic [2:0] PAT_PRBS15 = 3'h1;
  localparam logic [2:0] PAT_PRBS23 = 3'h2;
  localparam logic [2:0] PAT_PRBS31 = 3'h3;
  localparam logic [2:0] PAT_CLK2   = 3'h4;
  localparam logic [2:0] PAT_CLK10  = 3'h5;
  localparam logic [30:0] HIST_SEED = 31'h7fff_ffe0;
  localparam logic [5:0] LOCK_BITS  = 6'h20;

  // ***************************************
  // sweep and timing
  // ***************************************
  localparam int SW_NUM = 6;
  localparam int SW_SAMPLE = 5;
  localparam logic [7:0] SAMPLE_MAX = 8'h7f;
  localparam int MCLK_MHZ = 10;
  localparam int CM_RST_NS = 1000;
  localparam int CM_RST_CYC = (CM_RST_NS * MCLK_MHZ + 999) / 1000;
  localparam int FREQ_GATE_US = 1000;

  typedef enum logic [3:0] {
    SLBET_SW_IDLE  = 4'b0001,
    SLBET_SW_RUN   = 4'b0010,
    SLBET_SW_PAUSE = 4'b0100,
    SLBET_SW_DONE  = 4'b1000
  } slbet_sw_e;

endpackage

// ==== verilog/slbet_pattern.sv ====
`timescale 1ns/1ns
module slbet_pattern
  import slbet_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       step_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       bit_i,
  output logic            predict_o
);

  logic [30:0] hist_reg;

  // next bit predicted from bit history
  always_comb begin
    case (sel_i)
      PAT_PRBS7:  predict_o = hist_reg[6] ^ hist_reg[5];
      PAT_PRBS15: predict_o = hist_reg[14] ^ hist_reg[13];
      PAT_PRBS23: predict_o = hist_reg[22] ^ hist_reg[17];
      PAT_PRBS31: predict_o = hist_reg[30] ^ hist_reg[27];
      PAT_CLK2:   predict_o = ~hist_reg[0];
      // runs of five equal bits, then flip
      PAT_CLK10:  predict_o = (hist_reg[4:0] == 5'h1f || hist_reg[4:0] == 5'h00) ? ~hist_reg[0] : hist_reg[0];
      default:    predict_o = 1'b0;
    endcase
  end

  // history shifts one bit per link bit
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      hist_reg <= HIST_SEED;
    end else if (step_i) begin
      hist_reg <= {hist_reg[29:0], bit_i};
    end
  end

endmodule

// ==== verif/slbet_top_asserts.sv ====
`timescale 1ns/1ns
module slbet_top_asserts (
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       dcfg_en_o,
  input wire logic       dcfg_we_o,
  input wire logic       tx_cm_reset_o,
  input wire logic       rx_cm_reset_o,
  input wire logic       rx_ac_couple_o,
  input wire logic       tx_serial_o
);
  // ****
  // port checks
  // ****
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // pending plain request
  wire pend = (avs_read_i | avs_write_i) & avs_waitrequest_o & (avs_address_i != 8'h28);
  bus_answer_a: assert property (pend |=> !avs_waitrequest_o) else $error("late answer");
  cfg_pulse_a: assert property (dcfg_en_o |=> !dcfg_en_o) else $error("long enable");
  cfg_we_a: assert property (dcfg_we_o |-> dcfg_en_o) else $error("lone write");
  cfg_cause_a: assert property ($rose(dcfg_en_o) |-> $past(avs_address_i) == 8'h28)
    else $error("stray enable");
  logic [4:0] txcm_run;
  logic [4:0] rxcm_run;
  // consecutive high cycles of each clock manager reset
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      txcm_run <= 5'h00;
      rxcm_run <= 5'h00;
    end else begin
      txcm_run <= tx_cm_reset_o ? txcm_run + 5'h01 : 5'h00;
      rxcm_run <= rx_cm_reset_o ? rxcm_run + 5'h01 : 5'h00;
    end
  end
  txcm_len_a: assert property ((tx_cm_reset_o |-> txcm_run < 5'h0a) and ($fell(tx_cm_reset_o) |-> txcm_run == 5'h0a))
    else $error("tx pulse");
  rxcm_len_a: assert property ((rx_cm_reset_o |-> rxcm_run < 5'h0a) and ($fell(rx_cm_reset_o) |-> rxcm_run == 5'h0a))
    else $error("rx pulse");
  reset_out_a: assert property (disable iff (1'b0) !resetn_i |=> rx_ac_couple_o && !dcfg_en_o)
    else $error("reset value");
  tx_bit_a: assert property ($changed(tx_serial_o) |=> $stable(tx_serial_o)[*4]) else $error("tx bit");
  cover property ($rose(tx_cm_reset_o));
  cover property (dcfg_en_o && dcfg_we_o);
  cover property ($fell(avs_waitrequest_o) && avs_write_i);
endmodule
bind slbet_top slbet_top_asserts chk_i (.*);

// ==== verif/slbet_link.sv ====
`timescale 1ns/1ns
module slbet_link (
  input  wire logic tx_i,
  input  wire logic flip_i,
  output logic      link_clk_o,
  output logic      rx_o
);
  logic held;
  // free running bit clock, 800 ns
  initial begin
    link_clk_o = 0;
    rx_o = 0;
    held = 0;
    #137;
    forever #400 link_clk_o = ~link_clk_o;
  end
  // loopback path: take at rise, show at fall
  always @(posedge link_clk_o) held = tx_i;
  always @(negedge link_clk_o) rx_o <= held ^ flip_i;
endmodule

// ==== verif/slbet_tb_top.sv ====
`timescale 1ns/1ns
module slbet_tb_top;
  import slbet_pkg::*;
  logic        mclk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, dcfg_rdy_i = 0, flip = 0, uck = 0, uck2 = 0;
  logic [7:0]  avs_address_i = 8'h00, dcfg_addr_o, tx_swing_o, tx_preemph_o, receive_equalization_o;
  logic [7:0]  feedback_eq_tap_one_o, feedback_eq_tap_two_o;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, d;
  logic [15:0] dcfg_do_i = 16'h0000, dcfg_di_o, port_ctrl_o, cfg_mem [256];
  logic [6:0]  rx_sample_o;
  logic [1:0]  rx_term_sel_o;
  logic        avs_waitrequest_o, tx_serial_o, tx_cm_reset_o, rx_cm_reset_o, dcfg_en_o, dcfg_we_o;
  logic        rx_ac_couple_o, link_clk_i, rx_serial_i;
  wire  [3:0]  avs_byteenable_i = 4'hf;
  wire  [15:0] port_stat_i = 16'h5a5a;
  wire         tx_user_clock_i = uck, rx_user_clock_i = uck, tx_user_clock_half_i = uck2, rx_user_clock_half_i = uck2;
  int          bad_count = 0, compares = 0;
  logic [31:0] rng [6] = '{32'h0000_0201, 0, 32'h0000_0303, 32'h0000_0202, 32'h0000_0504, 32'h0000_0707};
  slbet_top #(.FREQ_GATE_CYC(100)) dut (.*);
  slbet_link link_i (.tx_i(tx_serial_o), .flip_i(flip), .link_clk_o(link_clk_i), .rx_o(rx_serial_i));
  // clocks: system 100 ns, user clocks 1 us and 2 us
  always #50 mclk_i = ~mclk_i;
  always #500 uck = ~uck;
  always @(posedge uck) uck2 = ~uck2;
  // config port stand-in, answers one cycle after enable
  always @(posedge mclk_i) begin
    dcfg_rdy_i <= dcfg_en_o;
    if (dcfg_en_o) begin
      dcfg_do_i <= cfg_mem[dcfg_addr_o];
      if (dcfg_we_o) cfg_mem[dcfg_addr_o] <= dcfg_di_o;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus transfer, held until waitrequest seen low
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
    int n;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= wd;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 99);
    r = avs_readdata_o;
    if (n >= 99) begin
      bad_count++;
      final_report();
    end
    avs_read_i <= 0;
    avs_write_i <= 0;
    @(posedge mclk_i);
  endtask
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1;
    bus(8'h00, 0, 0, d); chk(d, CTRL_RESET);
    for (int p = 0; p < 6; p++) begin
      bus(8'h00, 1, 32'h0000_0004 | (p << 8) | (p << 12), d);
      repeat (400) @(posedge mclk_i);
      bus(8'h04, 1, 32'h0000_0001, d);
      repeat (400) @(posedge mclk_i);
      bus(8'h10, 0, 0, d); chk(d, 0);
      bus(8'h08, 0, 0, d); chk(32'(d[0]), 1);
      bus(8'h04, 1, 32'h0000_0002, d);
      repeat (200) @(posedge mclk_i);
      bus(8'h10, 0, 0, d); chk(d, 1);
    end
    bus(8'h04, 1, 32'h0000_0001, d);
    repeat (800) @(posedge mclk_i);
    bus(8'h0c, 0, 0, d); chk(32'(d >= 98 && d <= 102), 1);
    bus(8'h00, 1, 32'h0000_1004, d);
    repeat (400) @(posedge mclk_i);
    bus(8'h08, 0, 0, d); chk(32'(d[0]), 0);
    flip <= 1;
    bus(8'h00, 1, 32'h0000_0005, d);
    repeat (400) @(posedge mclk_i);
    bus(8'h04, 1, 32'h0000_0001, d);
    repeat (400) @(posedge mclk_i);
    bus(8'h10, 0, 0, d); chk(d, 0);
    bus(8'h08, 0, 0, d); chk(32'(d[0]), 1);
    bus(8'h00, 1, 32'h0000_000f, d); chk(32'(rx_term_sel_o), 1);
    repeat (400) @(posedge mclk_i);
    bus(8'h08, 0, 0, d); chk(32'(d[0]), 0);
    bus(8'h04, 1, 32'h0000_000c, d);
    bus(8'h08, 0, 0, d); chk(32'(d[3:2]), 3);
    bus(8'h24, 1, 32'h0000_0012, d);
    bus(8'h28, 1, 32'h0000_abcd, d); chk(32'(cfg_mem[8'h12]), 32'h0000_abcd);
    bus(8'h28, 0, 0, d); chk(32'(d[15:0]), 32'h0000_abcd);
    bus(8'h2c, 1, 32'h0000_1234, d); chk(32'(port_ctrl_o), 32'h0000_1234);
    bus(8'h30, 1, 0, d); bus(8'h30, 0, 0, d); chk(d, 32'h0000_5a5a);
    bus(8'hfc, 0, 0, d); chk(d, 0);
    for (int i = 0; i < 6; i++) bus(8'h40 + 8'(4 * i), 1, rng[i], d);
    bus(8'h34, 1, 32'h0000_0028, d);
    bus(8'h3c, 0, 0, d); chk(d, 4);
    bus(8'h04, 1, 32'h0000_0010, d);
    repeat (50) @(posedge mclk_i);
    bus(8'h04, 1, 32'h0000_0020, d);
    bus(8'h38, 0, 0, d);
    chk(32'(tx_swing_o), 32'(d[1]) + 1);
    chk(32'(feedback_eq_tap_two_o), 32'(d[0]) + 4);
    chk(32'(rx_sample_o) + 32'(tx_preemph_o), 7);
    chk(32'(receive_equalization_o) + 32'(feedback_eq_tap_one_o), 5);
    bus(8'h04, 1, 32'h0000_0040, d);
    for (int k = 0; k < 200 && d[7:4] !== 4'h8; k++) bus(8'h08, 0, 0, d);
    chk(32'(d[7:4]), 8);
    chk(32'(tx_swing_o) + 32'(feedback_eq_tap_two_o), 7);
    bus(8'h04, 1, 32'h0000_0080, d); bus(8'h08, 0, 0, d); chk(32'(d[7:4]), 1);
    for (int i = 0; i < 4; i++) begin
      bus(8'h14 + 8'(4 * i), 0, 0, d);
      chk(32'(d + (i % 2) * 5 >= 9 && d + (i % 2) * 5 <= 11), 1);
    end
    final_report();
  end
endmodule
